// ===== hw/gsb_pkg.sv
// Purpose: constants shared by the grouped status read bus member logic
// Assumes: 8-bit host data bus, register offsets as byte addresses on that bus
// Notes: control fields only keep their defined bits; unused bits read as zero
package gsb_pkg;

    localparam int unsigned GSB_DW = 8;
    localparam int unsigned GSB_AW = 8;
    localparam int unsigned GSB_SELW = 3;
    localparam int unsigned GSB_GRPW = 2;
    localparam int unsigned GSB_SRC_N = 8;

    typedef logic [GSB_DW-1:0] gsb_byte_t;
    typedef logic [GSB_AW-1:0] gsb_addr_t;
    typedef logic [GSB_SELW-1:0] gsb_sel_t;
    typedef logic [GSB_GRPW-1:0] gsb_grp_t;
    typedef logic [GSB_SRC_N-1:0] gsb_src_t;

    // register offsets
    localparam gsb_addr_t GSB_OFS_CTL_A = 8'hb0;
    localparam gsb_addr_t GSB_OFS_CTL_B = 8'hb1;
    localparam gsb_addr_t GSB_OFS_VIEW_INT = 8'hb2;
    localparam gsb_addr_t GSB_OFS_VIEW_SYNC = 8'hb3;
    localparam gsb_addr_t GSB_OFS_VIEW_A = 8'hb4;
    localparam gsb_addr_t GSB_OFS_VIEW_B = 8'hb5;

    // reset values and writable masks
    localparam gsb_byte_t GSB_CTL_A_RST = 8'h00;
    localparam gsb_byte_t GSB_CTL_B_RST = 8'h00;
    localparam gsb_byte_t GSB_CTL_A_MASK = 8'h0f;
    localparam gsb_byte_t GSB_CTL_B_MASK = 8'h77;
    localparam gsb_byte_t GSB_BYTE_ZERO = 8'h00;

    // field positions
    localparam int unsigned GSB_EN_BIT = 0;
    localparam int unsigned GSB_LINE_LSB = 1;
    localparam int unsigned GSB_SEL_A_LSB = 0;
    localparam int unsigned GSB_SEL_B_LSB = 4;

    // group select line codes, one per information register
    localparam gsb_grp_t GSB_GRP_INT = 2'h0;
    localparam gsb_grp_t GSB_GRP_SYNC = 2'h1;
    localparam gsb_grp_t GSB_GRP_VIEW_A = 2'h2;
    localparam gsb_grp_t GSB_GRP_VIEW_B = 2'h3;

    // user status source codes
    localparam gsb_sel_t GSB_SRC_BLUE = 3'h0;
    localparam gsb_sel_t GSB_SRC_YELLOW = 3'h1;
    localparam gsb_sel_t GSB_SRC_LOOP_UP = 3'h2;
    localparam gsb_sel_t GSB_SRC_LOOP_DOWN = 3'h3;
    localparam gsb_sel_t GSB_SRC_SIG_CHG = 3'h4;
    localparam gsb_sel_t GSB_SRC_SLIP = 3'h5;

    localparam logic [1:0] GSB_RST_SYNC_CLR = 2'h0;

endpackage

// ===== hw/gsb_status_if.sv
// Purpose: carries alarm sources and view selections between member top and selector
// Assumes: source vectors indexed by source code
// Notes: unassigned codes carry zero
`timescale 1ns/1ps
interface gsb_status_if;
    import gsb_pkg::*;
    logic e1_mode;
    gsb_src_t t1_src;
    gsb_src_t e1_src;
    gsb_sel_t sel_a;
    gsb_sel_t sel_b;
    logic view_a;
    logic view_b;

    modport top (output e1_mode, output t1_src, output e1_src, output sel_a, output sel_b,
                 input view_a, input view_b);
    modport sel (input e1_mode, input t1_src, input e1_src, input sel_a, input sel_b,
                 output view_a, output view_b);
endinterface

// ===== hw/gsb_view_sel.sv
// Purpose: picks the user-selected status bits for the third and fourth views
// Assumes: line mode input selects between the two source sets
// Notes: purely combinational
`timescale 1ns/1ps
module gsb_view_sel
    import gsb_pkg::*;
(
    gsb_status_if.sel st
);

    function automatic logic pick(input gsb_sel_t code, input logic e1, input gsb_src_t t1s,
                                  input gsb_src_t e1s);
        pick = e1 ? e1s[code] : t1s[code];
    endfunction

    assign st.view_a = pick(st.sel_a, st.e1_mode, st.t1_src, st.e1_src);
    assign st.view_b = pick(st.sel_b, st.e1_mode, st.t1_src, st.e1_src);

endmodule // gsb_view_sel

// ===== hw/gsb_top.sv
// Purpose: one group member of the shared status read bus
// Assumes: host port inputs synchronous to i_sys_clk; group lines resolved outside
// Notes: each transceiver instantiates one member, so two quads give eight members
`timescale 1ns/1ps

// Behaviour
// - one read of any member returns status bits from all up to eight members
// - on grouped reads a member drives only its own data bit
// - reads of view registers are broadcast on two select lines and a strobe
// - every transceiver is a separate member; eight may share one group
// - bit 0 of control a enables participation, reset disabled
// - bits 1 to 3 of control a pick the driven data line 0 to 7
// - bits 0 to 2 of control b choose third view status source
// - bits 4 to 6 of control b choose fourth view source, same mapping
// - interrupt view read puts interrupt pending on selected line
// - sync view read puts frame sync loss on selected line
// - third view read puts third selected status on line
// - fourth view read puts fourth selected status on line
module gsb_top
    import gsb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire gsb_pkg::gsb_addr_t i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire gsb_pkg::gsb_byte_t i_wdata,
    output logic [gsb_pkg::GSB_DW-1:0] o_bus_data,
    output logic [gsb_pkg::GSB_DW-1:0] o_bus_oe,
    input wire gsb_pkg::gsb_grp_t i_grp_sel,
    input wire logic i_grp_rd,
    output gsb_pkg::gsb_grp_t o_grp_sel,
    output logic o_grp_sel_oe,
    output logic o_grp_rd,
    output logic o_grp_rd_oe,
    input wire logic i_interrupt_flag,
    input wire logic i_sync_loss_flag,
    input wire logic i_e1_mode,
    input wire logic i_blue_alarm,
    input wire logic i_all_ones_receive,
    input wire logic i_yellow_alarm,
    input wire logic i_remote_alarm,
    input wire logic i_loop_up_code,
    input wire logic i_multiframe_alarm,
    input wire logic i_loop_down_code,
    input wire logic i_link_id_detect,
    input wire logic i_signalling_change,
    input wire logic i_elastic_store_slip
);
    import gsb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rst_sync_ff <= GSB_RST_SYNC_CLR;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_view(input gsb_addr_t a);
        is_view = (a == GSB_OFS_VIEW_INT) || (a == GSB_OFS_VIEW_SYNC) ||
                  (a == GSB_OFS_VIEW_A) || (a == GSB_OFS_VIEW_B);
    endfunction

    function automatic gsb_grp_t view_code(input gsb_addr_t a);
        gsb_addr_t d;
        d = a - GSB_OFS_VIEW_INT;
        view_code = d[GSB_GRPW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    gsb_byte_t ctl_a_ff;
    gsb_byte_t ctl_b_ff;
    gsb_byte_t nxt_ctl_a;
    gsb_byte_t nxt_ctl_b;
    logic enable;
    gsb_sel_t line_sel;

    always_comb
    begin
        nxt_ctl_a = ctl_a_ff;
        nxt_ctl_b = ctl_b_ff;
        // unused bits are dropped so they always read back zero
        if (i_wr && (i_addr == GSB_OFS_CTL_A))
            nxt_ctl_a = i_wdata & GSB_CTL_A_MASK;
        if (i_wr && (i_addr == GSB_OFS_CTL_B))
            nxt_ctl_b = i_wdata & GSB_CTL_B_MASK;
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_a_ff <= GSB_CTL_A_RST;
            ctl_b_ff <= GSB_CTL_B_RST;
        end
        else
        begin
            ctl_a_ff <= nxt_ctl_a;
            ctl_b_ff <= nxt_ctl_b;
        end
    end

    assign enable = ctl_a_ff[GSB_EN_BIT];
    assign line_sel = ctl_a_ff[GSB_LINE_LSB +: GSB_SELW];

    ////////////////////////////////////////////////////////////////////////////////
    // user status selection

    gsb_status_if st();

    assign st.e1_mode = i_e1_mode;
    assign st.sel_a = ctl_b_ff[GSB_SEL_A_LSB +: GSB_SELW];
    assign st.sel_b = ctl_b_ff[GSB_SEL_B_LSB +: GSB_SELW];

    always_comb
    begin
        st.t1_src = '0;
        st.e1_src = '0;
        st.t1_src[GSB_SRC_BLUE] = i_blue_alarm;
        st.e1_src[GSB_SRC_BLUE] = i_all_ones_receive;
        st.t1_src[GSB_SRC_YELLOW] = i_yellow_alarm;
        st.e1_src[GSB_SRC_YELLOW] = i_remote_alarm;
        st.t1_src[GSB_SRC_LOOP_UP] = i_loop_up_code;
        st.e1_src[GSB_SRC_LOOP_UP] = i_multiframe_alarm;
        st.t1_src[GSB_SRC_LOOP_DOWN] = i_loop_down_code;
        st.e1_src[GSB_SRC_LOOP_DOWN] = i_link_id_detect;
        st.t1_src[GSB_SRC_SIG_CHG] = i_signalling_change;
        st.e1_src[GSB_SRC_SIG_CHG] = i_signalling_change;
        st.t1_src[GSB_SRC_SLIP] = i_elastic_store_slip;
        st.e1_src[GSB_SRC_SLIP] = i_elastic_store_slip;
    end

    gsb_view_sel u_view_sel
    (
        .st(st)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // group lines and data bus drive

    logic grp_rd_ff;
    logic grp_oe_ff;
    gsb_grp_t grp_sel_ff;
    gsb_byte_t bus_data_ff;
    gsb_byte_t bus_oe_ff;
    logic nxt_grp_rd;
    logic nxt_grp_oe;
    gsb_grp_t nxt_grp_sel;
    gsb_byte_t nxt_bus_data;
    gsb_byte_t nxt_bus_oe;
    logic host_view;
    logic grp_active;
    logic member_bit;

    always_comb
    begin
        // the local view read is broadcast, this member answers through the same lines
        host_view = i_rd && is_view(i_addr) && enable;
        nxt_grp_rd = host_view;
        nxt_grp_oe = host_view;
        nxt_grp_sel = host_view ? view_code(i_addr) : GSB_GRP_INT;
        grp_active = i_grp_rd && enable;
        case (i_grp_sel)
            GSB_GRP_INT: member_bit = i_interrupt_flag;
            GSB_GRP_SYNC: member_bit = i_sync_loss_flag;
            GSB_GRP_VIEW_A: member_bit = st.view_a;
            GSB_GRP_VIEW_B: member_bit = st.view_b;
            default: member_bit = 1'b0;
        endcase
        nxt_bus_data = GSB_BYTE_ZERO;
        nxt_bus_oe = GSB_BYTE_ZERO;
        if (grp_active)
        begin
            // single bit only; a peer owns every other line
            nxt_bus_oe[line_sel] = 1'b1;
            nxt_bus_data[line_sel] = member_bit;
        end
        else if (i_rd && (i_addr == GSB_OFS_CTL_A))
        begin
            nxt_bus_oe = ~GSB_BYTE_ZERO;
            nxt_bus_data = ctl_a_ff;
        end
        else if (i_rd && (i_addr == GSB_OFS_CTL_B))
        begin
            nxt_bus_oe = ~GSB_BYTE_ZERO;
            nxt_bus_data = ctl_b_ff;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grp_rd_ff <= 1'b0;
            grp_oe_ff <= 1'b0;
            grp_sel_ff <= GSB_GRP_INT;
            bus_data_ff <= GSB_BYTE_ZERO;
            bus_oe_ff <= GSB_BYTE_ZERO;
        end
        else
        begin
            grp_rd_ff <= nxt_grp_rd;
            grp_oe_ff <= nxt_grp_oe;
            grp_sel_ff <= nxt_grp_sel;
            bus_data_ff <= nxt_bus_data;
            bus_oe_ff <= nxt_bus_oe;
        end
    end

    assign o_grp_rd = grp_rd_ff;
    assign o_grp_rd_oe = grp_oe_ff;
    assign o_grp_sel = grp_sel_ff;
    assign o_grp_sel_oe = grp_oe_ff;
    assign o_bus_data = bus_data_ff;
    assign o_bus_oe = bus_oe_ff;

endmodule // gsb_top

// ===== verif/gsb_top_monitor.sv
// Purpose: port checks for one group member
// Assumes: group lines resolved outside and fed back
// Notes: control state is hidden, so outputs are tied to past inputs
`timescale 1ns/1ps
module gsb_top_monitor
    import gsb_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire gsb_pkg::gsb_addr_t i_addr,
    input wire logic i_rd,
    input wire gsb_pkg::gsb_grp_t i_grp_sel,
    input wire logic i_grp_rd,
    input wire logic i_interrupt_flag,
    input wire logic i_sync_loss_flag,
    input wire logic [gsb_pkg::GSB_DW-1:0] o_bus_data,
    input wire logic [gsb_pkg::GSB_DW-1:0] o_bus_oe,
    input wire gsb_pkg::gsb_grp_t o_grp_sel,
    input wire logic o_grp_sel_oe,
    input wire logic o_grp_rd,
    input wire logic o_grp_rd_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    logic ans;
    // a single driven bit marks a group answer, full byte a control read
    assign ans = (o_bus_oe != 8'h00) && (o_bus_oe != 8'hff);
    ////////////////////////////////////////////////////////////////
    a_strobe_cause: assert property (o_grp_rd |-> $past(i_rd) && ($past(i_addr) inside {[8'hb2:8'hb5]}))
        else $error("group strobe without view read");
    a_sel_code: assert property (o_grp_rd |-> o_grp_sel == $past(i_addr[1:0]) - 2'h2)
        else $error("group select code wrong");
    a_strobe_oe: assert property (o_grp_rd |-> o_grp_rd_oe && o_grp_sel_oe)
        else $error("group strobe not enabled");
    a_sel_idle_low: assert property (!o_grp_sel_oe |-> o_grp_sel == 2'h0)
        else $error("select driven while released");
    a_one_line: assert property (o_bus_oe != 8'hff |-> $onehot0(o_bus_oe))
        else $error("more than one data line driven");
    a_answer_cause: assert property (ans |-> $past(i_grp_rd))
        else $error("data line driven without strobe");
    a_int_value: assert property (ans && $past(i_grp_sel) == 2'h0 |->
        |(o_bus_data & o_bus_oe) == $past(i_interrupt_flag))
        else $error("interrupt view bit wrong");
    a_sync_value: assert property (ans && $past(i_grp_sel) == 2'h1 |->
        |(o_bus_data & o_bus_oe) == $past(i_sync_loss_flag))
        else $error("sync view bit wrong");
    a_ctl_cause: assert property (o_bus_oe == 8'hff |-> $past(i_rd) && ($past(i_addr) inside {8'hb0, 8'hb1}))
        else $error("full byte driven without control read");
endmodule // gsb_top_monitor
bind gsb_top gsb_top_monitor u_mon (.*);

// ===== verif/gsb_peer_model.sv
// Purpose: resolves the shared group lines and plays a peer member
// Assumes: lines pulled low when nobody drives
// Notes: peer only requests; its own data bit is left out
`timescale 1ns/1ps
module gsb_peer_model
    import gsb_pkg::*;
(
    input wire logic i_req,
    input wire gsb_pkg::gsb_grp_t i_req_sel,
    input wire gsb_pkg::gsb_grp_t i_uut_sel,
    input wire logic i_uut_sel_oe,
    input wire logic i_uut_rd,
    input wire logic i_uut_rd_oe,
    output gsb_pkg::gsb_grp_t o_grp_sel,
    output logic o_grp_rd
);
    // wired result of uut and peer drivers
    assign o_grp_rd = (i_uut_rd_oe & i_uut_rd) | i_req;
    assign o_grp_sel = i_uut_sel_oe ? i_uut_sel : (i_req ? i_req_sel : 2'h0);
endmodule // gsb_peer_model

// ===== verif/tb_top.sv
// Purpose: self-checking bench for one group member
// Assumes: peer model resolves group lines
// Notes: status inputs change only between reads
`timescale 1ns/1ps
module tb_top;
    import gsb_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    gsb_addr_t addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic req = 1'b0;
    logic e1 = 1'b0;
    gsb_byte_t wdata = 8'h00;
    gsb_grp_t req_sel = 2'h0;
    logic [11:0] stv = 12'h000;
    gsb_byte_t bd, boe;
    gsb_grp_t usel, gsel;
    gsb_byte_t got_oe, got_data;
    gsb_grp_t got_sel;
    logic usel_oe, urd, urd_oe, grd;
    int fail_count = 0;
    int n_compared = 0;
    int ma = 0;
    int mb = 0;
    int seen = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    gsb_top uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
        .o_bus_data(bd), .o_bus_oe(boe), .i_grp_sel(gsel), .i_grp_rd(grd), .o_grp_sel(usel),
        .o_grp_sel_oe(usel_oe), .o_grp_rd(urd), .o_grp_rd_oe(urd_oe), .i_interrupt_flag(stv[0]),
        .i_sync_loss_flag(stv[1]), .i_e1_mode(e1), .i_blue_alarm(stv[2]), .i_all_ones_receive(stv[3]),
        .i_yellow_alarm(stv[4]), .i_remote_alarm(stv[5]), .i_loop_up_code(stv[6]), .i_multiframe_alarm(stv[7]),
        .i_loop_down_code(stv[8]), .i_link_id_detect(stv[9]), .i_signalling_change(stv[10]),
        .i_elastic_store_slip(stv[11]));
    gsb_peer_model peer (.i_req(req), .i_req_sel(req_sel), .i_uut_sel(usel), .i_uut_sel_oe(usel_oe),
        .i_uut_rd(urd), .i_uut_rd_oe(urd_oe), .o_grp_sel(gsel), .o_grp_rd(grd));
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input gsb_byte_t exp, input gsb_byte_t got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input gsb_addr_t a, input gsb_byte_t d);
        @(posedge i_sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask
    // host read held four cycles; the view answer appears two cycles after the read starts
    task automatic rd_reg(input gsb_addr_t a, input logic by_peer);
        @(posedge i_sys_clk);
        addr <= a;
        rd <= !by_peer;
        req <= by_peer;
        req_sel <= a[1:0] - 2'h2;
        seen = 0;
        repeat (3)
        begin
            @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            seen = seen | urd_oe | usel_oe;
            // taken while the request still stands; the answer drops soon after release
            got_oe = boe;
            got_data = bd;
            got_sel = usel;
        end
        @(posedge i_sys_clk);
        rd <= 1'b0;
        req <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
    endtask
    function automatic logic src(input int c);
        case (c)
            0, 1, 2, 3: return stv[2 + 2 * c + e1];
            4: return stv[10];
            5: return stv[11];
            default: return 1'b0;
        endcase
    endfunction
    task automatic view(input int g, input logic by_peer);
        gsb_byte_t eoe;
        logic b;
        eoe = (ma & 1) ? 8'h01 << ((ma >> 1) & 7) : 8'h00;
        b = (g == 0) ? stv[0] : (g == 1) ? stv[1] : src((g == 2) ? (mb & 7) : ((mb >> 4) & 7));
        rd_reg(8'(8'hb2 + g), by_peer);
        chk("view oe", eoe, got_oe);
        chk("view data", b ? eoe : 8'h00, got_data & got_oe);
        chk("select code", (!by_peer && (ma & 1)) ? 8'(g) : 8'h00, 8'(got_sel));
        if (!by_peer)
            chk("strobe", (ma & 1) ? 8'h01 : 8'h00, 8'(seen));
    endtask
    task automatic ctl(input gsb_addr_t a, input int m);
        rd_reg(a, 1'b0);
        chk("ctl oe", 8'hff, got_oe);
        chk("ctl data", 8'(m), got_data);
    endtask
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'h250c));
        repeat (12) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        ctl(8'hb0, 0);
        ctl(8'hb1, 0);
        for (int g = 0; g < 4; g++)
        begin
            view(g, 1'b0);
            view(g, 1'b1);
        end
        rd_reg(8'hb6, 1'b0);
        chk("unmapped oe", 8'h00, got_oe);
        $display("test reset_and_disabled done");
        for (int i = 0; i < 17; i++)
        begin
            // line i%8 keeps peer lines distinct, unused bits set on purpose
            ma = (i < 16) ? {4'($urandom_range(15, 0)), 3'(i), 1'b1} : 8'h0e;
            mb = {1'($urandom_range(1, 0)), 3'(i + 3), 1'($urandom_range(1, 0)), 3'(i)};
            wr_reg(8'hb0, 8'(ma));
            wr_reg(8'hb1, 8'(mb));
            ma = ma & 8'h0f;
            mb = mb & 8'h77;
            ctl(8'hb0, ma);
            ctl(8'hb1, mb);
            @(posedge i_sys_clk);
            stv <= 12'($urandom);
            e1 <= i[3];
            @(posedge i_sys_clk);
            for (int g = 0; g < 4; g++)
            begin
                view(g, 1'b0);
                view(g, 1'b1);
            end
        end
        $display("test grouped_views done");
        // reset in mid-run must bring both control registers back to zero
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        ctl(8'hb0, 0);
        ctl(8'hb1, 0);
        $display("test mid_reset done");
        print_verdict();
    end
endmodule // tb_top
